// [src/ttc_pkg.sv]
// shared constants and types for the two-tap camera video link
package ttc_pkg;

  // ---------------------------------------------------------------
  // clock and serial timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BAUD_RATE      = 9600;
  localparam int unsigned SER_BIT_CYC    = (CLK_MHZ * 1000000) / BAUD_RATE;
  localparam int unsigned SER_DATA_BITS  = 8;

  // ---------------------------------------------------------------
  // trigger and frame timing
  // ---------------------------------------------------------------
  localparam int unsigned TRIG_MIN_US    = 12;
  localparam int unsigned TRIG_MIN_CYC   = TRIG_MIN_US * CLK_MHZ;
  localparam int unsigned INTEG_MIN_US   = 10;
  localparam int unsigned INTEG_MIN_CYC  = INTEG_MIN_US * CLK_MHZ;
  localparam int unsigned TRANSFER_US    = 82;
  localparam int unsigned TRANSFER_CYC   = TRANSFER_US * CLK_MHZ;
  localparam int unsigned FRAME_MIN_NS_K = 16129;  // 16.129 ms in us
  localparam int unsigned FRAME_MIN_CYC  = FRAME_MIN_NS_K * CLK_MHZ;
  localparam int unsigned FRAME_MAX_MS   = 1000;
  localparam int unsigned FRAME_MAX_CYC  = FRAME_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned PCLK_HALF_CYC  = 8;      // 64 ns pixel period
  localparam int unsigned OVERHEAD_PIX   = 16;

  // ---------------------------------------------------------------
  // output modes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_2TAP_8     = 2'h2;
  localparam logic [1:0] MODE_2TAP_10    = 2'h3;
  localparam logic [7:0] PORT_IDLE       = 8'h00;
  localparam logic       SER_IDLE        = 1'b1;

  typedef enum logic [3:0] {
    FR_IDLE = 4'b0001,
    FR_WAIT = 4'b0010,
    FR_LINE = 4'b0100,
    FR_GAP  = 4'b1000
  } ttc_frame_e;

  typedef enum logic [1:0] {
    TG_IDLE = 2'b01,
    TG_HIGH = 2'b10
  } ttc_trig_e;

endpackage

// [src/ttc_link_if.sv]
// link between camera end and frame grabber end
`timescale 1ns/1ps
interface ttc_link_if;
  logic       pix_clk;
  logic       fval;
  logic       lval;
  logic       dval;
  logic [7:0] port_a;
  logic [7:0] port_b;
  logic [7:0] port_c;
  logic       frame_trigger_pulse;
  logic [2:0] cc_rsv;
  logic       ser_to_fg;
  logic       ser_to_cam;

  modport cam (
    output pix_clk, fval, lval, dval, port_a, port_b, port_c, ser_to_fg,
    input  frame_trigger_pulse, cc_rsv, ser_to_cam
  );
  modport grab (
    input  pix_clk, fval, lval, dval, port_a, port_b, port_c, ser_to_fg,
    output frame_trigger_pulse, cc_rsv, ser_to_cam
  );
endinterface

// [src/ttc_cam_end.sv]
// camera end: serial port, trigger response and two-tap video output
//
// Summary of operation
// - serial: one start, one stop, no parity
// - serial runs at 9600 baud or more
// - separate lines to grabber and to camera
// - grabber holds trigger at least 12 us
// - pulse-width integration at least 10 us
// - frame period 16.129 ms to 1000 ms
// - fval rises 82 us after trigger fall
// - grabber waits overhead after fval falls
// - first lval rises with fval
// - fval falls with last lval
// - taps carry pixel pairs 0,1 then onward
// - 8/10-bit port A/B bit mapping
// - 10-bit: port C carries tap B low
// - mode 2 is 8-bit, 3 is 10-bit
// - fval over frame, lval over pixels
// - unused data bits held at zero
// - trigger on first control line only
`timescale 1ns/1ps

// ---------------------------------------------------------------
// serial transceiver shared by both ends
// ---------------------------------------------------------------
module ttc_uart
  import ttc_pkg::*;
#(
  parameter int unsigned BIT_CYC = SER_BIT_CYC
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // transmit side
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            txd,
  // receive side
  input  wire logic       rxd,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_err
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL_M1 = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(BIT_CYC / 2 - 1);

  logic [8:0]    tx_sh_q, tx_sh_d;
  logic [CW-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]    tx_bits_q, tx_bits_d;
  logic          txd_q, txd_d, tx_idle_q, tx_idle_d;
  logic [2:0]    rx_s_q, rx_s_d;
  logic          rx_lvl_q, rx_lvl_d, rx_act_q, rx_act_d;
  logic [CW-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]    rx_bits_q, rx_bits_d;
  logic [7:0]    rx_sh_q, rx_sh_d, rx_dat_q, rx_dat_d;
  logic          rx_ok_q, rx_ok_d, rx_bad_q, rx_bad_d;

  // transmitter: start bit, eight data bits lsb first, stop bit
  // framing start stop
  always_comb
  begin
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    tx_bits_d = tx_bits_q;
    txd_d     = txd_q;
    tx_idle_d = tx_idle_q;
    if (tx_idle_q)
    begin
      if (tx_valid)
      begin
        tx_sh_d   = {1'b1, tx_data};
        txd_d     = 1'b0;
        tx_idle_d = 1'b0;
        tx_cnt_d  = '0;
        tx_bits_d = 4'h0;
      end
    end
    else if (tx_cnt_q == FULL_M1)
    begin
      tx_cnt_d = '0;
      if (tx_bits_q == 4'h9)
        tx_idle_d = 1'b1;
      else
      begin
        txd_d     = tx_sh_q[0];
        tx_sh_d   = {1'b1, tx_sh_q[8:1]};
        tx_bits_d = tx_bits_q + 4'h1;
      end
    end
    else
      tx_cnt_d = tx_cnt_q + CW'(1);
  end

  // receiver: synchronise, filter, sample mid bit, check stop bit
  always_comb
  begin
    rx_s_d    = {rx_s_q[1:0], rxd};
    rx_lvl_d  = (rx_s_q[1] == rx_s_q[2]) ? rx_s_q[2] : rx_lvl_q;
    rx_act_d  = rx_act_q;
    rx_cnt_d  = rx_cnt_q;
    rx_bits_d = rx_bits_q;
    rx_sh_d   = rx_sh_q;
    rx_dat_d  = rx_dat_q;
    rx_ok_d   = 1'b0;
    rx_bad_d  = 1'b0;
    if (!rx_act_q)
    begin
      if (!rx_lvl_q)
      begin
        rx_act_d  = 1'b1;
        rx_cnt_d  = '0;
        rx_bits_d = 4'h0;
      end
    end
    else if (rx_cnt_q == ((rx_bits_q == 4'h0) ? HALF_M1 : FULL_M1))
    begin
      rx_cnt_d = '0;
      if (rx_bits_q == 4'h0)
      begin
        rx_act_d  = ~rx_lvl_q;  // glitch rather than start bit
        rx_bits_d = 4'h1;
      end
      else if (rx_bits_q == 4'h9)
      begin
        rx_act_d = 1'b0;
        rx_dat_d = rx_sh_q;
        rx_ok_d  = rx_lvl_q;
        rx_bad_d = ~rx_lvl_q;
      end
      else
      begin
        rx_sh_d   = {rx_lvl_q, rx_sh_q[7:1]};
        rx_bits_d = rx_bits_q + 4'h1;
      end
    end
    else
      rx_cnt_d = rx_cnt_q + CW'(1);
  end

  // serial state registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      tx_sh_q   <= '1;
      tx_cnt_q  <= '0;
      tx_bits_q <= 4'h0;
      txd_q     <= SER_IDLE;
      tx_idle_q <= 1'b1;
      rx_s_q    <= 3'h7;
      rx_lvl_q  <= SER_IDLE;
      rx_act_q  <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bits_q <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_dat_q  <= 8'h00;
      rx_ok_q   <= 1'b0;
      rx_bad_q  <= 1'b0;
    end
    else
    begin
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bits_q <= tx_bits_d;
      txd_q     <= txd_d;
      tx_idle_q <= tx_idle_d;
      rx_s_q    <= rx_s_d;
      rx_lvl_q  <= rx_lvl_d;
      rx_act_q  <= rx_act_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bits_q <= rx_bits_d;
      rx_sh_q   <= rx_sh_d;
      rx_dat_q  <= rx_dat_d;
      rx_ok_q   <= rx_ok_d;
      rx_bad_q  <= rx_bad_d;
    end
  end

  assign tx_ready = tx_idle_q;
  assign txd      = txd_q;
  assign rx_data  = rx_dat_q;
  assign rx_valid = rx_ok_q;
  assign rx_err   = rx_bad_q;
endmodule

// ---------------------------------------------------------------
// camera end top
// ---------------------------------------------------------------
module ttc_cam_end
  import ttc_pkg::*;
#(
  parameter int unsigned BIT_CYC   = SER_BIT_CYC,
  parameter int unsigned XFER_CYC  = TRANSFER_CYC,
  parameter int unsigned PAIRS     = 700,
  parameter int unsigned LINES     = 1024,
  parameter int unsigned LINE_GAP  = 4
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // link
  ttc_link_if.cam         lnk,
  // pixel source
  input  wire logic [1:0] out_mode,
  input  wire logic [9:0] pix_a,
  input  wire logic [9:0] pix_b,
  output logic            pix_take,
  output logic            frame_busy,
  // serial user side
  input  wire logic [7:0] ser_tx_data,
  input  wire logic       ser_tx_valid,
  output logic            ser_tx_ready,
  output logic [7:0]      ser_rx_data,
  output logic            ser_rx_valid,
  output logic            ser_rx_err
);
  localparam int unsigned XW = $clog2(XFER_CYC + 1);
  localparam int unsigned PW = $clog2(PAIRS + 1);
  localparam int unsigned LW = $clog2(LINES + 1);
  localparam int unsigned GW = $clog2(LINE_GAP + 1);
  localparam int unsigned DW = $clog2(PCLK_HALF_CYC + 1);

  ttc_frame_e    st_q, st_d;
  logic [DW-1:0] div_q, div_d;
  logic          pclk_q, pclk_d, tick;
  logic [2:0]    trg_s_q, trg_s_d;
  logic          trg_q, trg_d;
  logic [XW-1:0] dly_q, dly_d;
  logic [PW-1:0] col_q, col_d;
  logic [LW-1:0] row_q, row_d;
  logic [GW-1:0] gap_q, gap_d;
  logic          ten_q, ten_d;
  logic          fv_q, fv_d, lv_q, lv_d, dv_q, dv_d, take_q, take_d;
  logic [7:0]    pa_q, pa_d, pb_q, pb_d, pc_q, pc_d;
  logic [23:0]   map;

  // serial port on its own pair of one-way lines
  // separate lines
  ttc_uart #(.BIT_CYC(BIT_CYC)) u_ser (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .tx_data  (ser_tx_data),
    .tx_valid (ser_tx_valid),
    .tx_ready (ser_tx_ready),
    .txd      (lnk.ser_to_fg),
    .rxd      (lnk.ser_to_cam),
    .rx_data  (ser_rx_data),
    .rx_valid (ser_rx_valid),
    .rx_err   (ser_rx_err)
  );

  // pixel pair to port bits; unused bits stay zero
  always_comb
  begin
    if (ten_d)
      map = {pix_b[7:0], 2'b00, pix_b[9:8], 2'b00, pix_a[9:8], pix_a[7:0]};
    else
      map = {PORT_IDLE, pix_b[9:2], pix_a[9:2]};
  end

  // pixel clock divider, trigger filter and frame sequencer
  always_comb
  begin
    div_d   = (div_q == DW'(PCLK_HALF_CYC - 1)) ? '0 : div_q + DW'(1);
    pclk_d  = (div_q == DW'(PCLK_HALF_CYC - 1)) ? ~pclk_q : pclk_q;
    tick    = (div_q == DW'(PCLK_HALF_CYC - 1)) && pclk_q;  // falling pixel edge
    trg_s_d = {trg_s_q[1:0], lnk.frame_trigger_pulse};
    trg_d   = (trg_s_q[1] == trg_s_q[2]) ? trg_s_q[2] : trg_q;
    st_d    = st_q;
    dly_d   = dly_q;
    col_d   = col_q;
    row_d   = row_q;
    gap_d   = gap_q;
    ten_d   = ten_q;
    fv_d    = fv_q;
    lv_d    = lv_q;
    dv_d    = dv_q;
    pa_d    = pa_q;
    pb_d    = pb_q;
    pc_d    = pc_q;
    take_d  = 1'b0;
    case (st_q)
      FR_IDLE:
      begin
        if (trg_q && !trg_d)
        begin
          st_d  = FR_WAIT;
          dly_d = '0;
          ten_d = (out_mode == MODE_2TAP_10);
        end
      end
      FR_WAIT:
      begin
        if (dly_q < XW'(XFER_CYC - 1))
          dly_d = dly_q + XW'(1);
        else if (tick)
        begin
          st_d = FR_LINE;
          fv_d = 1'b1;
          lv_d = 1'b1;
          dv_d = 1'b1;
          col_d = '0;
          row_d = '0;
          {pc_d, pb_d, pa_d} = map;
          take_d = 1'b1;
        end
      end
      FR_LINE:
      begin
        if (tick)
        begin
          if (col_q == PW'(PAIRS - 1))
          begin
            lv_d = 1'b0;
            dv_d = 1'b0;
            {pc_d, pb_d, pa_d} = {PORT_IDLE, PORT_IDLE, PORT_IDLE};
            gap_d = '0;
            if (row_q == LW'(LINES - 1))
            begin
              fv_d = 1'b0;
              st_d = FR_IDLE;
            end
            else
              st_d = FR_GAP;
          end
          else
          begin
            col_d = col_q + PW'(1);
            {pc_d, pb_d, pa_d} = map;
            take_d = 1'b1;
          end
        end
      end
      FR_GAP:
      begin
        if (tick)
        begin
          if (gap_q == GW'(LINE_GAP - 1))
          begin
            st_d = FR_LINE;
            lv_d = 1'b1;
            dv_d = 1'b1;
            col_d = '0;
            row_d = row_q + LW'(1);
            {pc_d, pb_d, pa_d} = map;
            take_d = 1'b1;
          end
          else
            gap_d = gap_q + GW'(1);
        end
      end
      default:
        st_d = FR_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_q    <= FR_IDLE;
      div_q   <= '0;
      pclk_q  <= 1'b0;
      trg_s_q <= 3'h0;
      trg_q   <= 1'b0;
      dly_q   <= '0;
      col_q   <= '0;
      row_q   <= '0;
      gap_q   <= '0;
      ten_q   <= 1'b0;
      fv_q    <= 1'b0;
      lv_q    <= 1'b0;
      dv_q    <= 1'b0;
      pa_q    <= PORT_IDLE;
      pb_q    <= PORT_IDLE;
      pc_q    <= PORT_IDLE;
      take_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      div_q   <= div_d;
      pclk_q  <= pclk_d;
      trg_s_q <= trg_s_d;
      trg_q   <= trg_d;
      dly_q   <= dly_d;
      col_q   <= col_d;
      row_q   <= row_d;
      gap_q   <= gap_d;
      ten_q   <= ten_d;
      fv_q    <= fv_d;
      lv_q    <= lv_d;
      dv_q    <= dv_d;
      pa_q    <= pa_d;
      pb_q    <= pb_d;
      pc_q    <= pc_d;
      take_q  <= take_d;
    end
  end

  // link and user outputs
  assign lnk.pix_clk = pclk_q;
  assign lnk.fval    = fv_q;
  assign lnk.lval    = lv_q;
  assign lnk.dval    = dv_q;
  assign lnk.port_a  = pa_q;
  assign lnk.port_b  = pb_q;
  assign lnk.port_c  = pc_q;
  assign pix_take    = take_q;
  assign frame_busy  = fv_q;
endmodule

// [src/ttc_grab_end.sv]
// frame grabber end: trigger generator, video capture and serial port
`timescale 1ns/1ps
module ttc_grab_end
  import ttc_pkg::*;
#(
  parameter int unsigned BIT_CYC  = SER_BIT_CYC,
  parameter int unsigned PER_MIN  = FRAME_MIN_CYC,
  parameter int unsigned PER_MAX  = FRAME_MAX_CYC,
  parameter int unsigned OVH_PIX  = OVERHEAD_PIX
)(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // link
  ttc_link_if.grab         lnk,
  // trigger request
  input  wire logic        trig_req,
  input  wire logic [31:0] trig_width,
  output logic             trig_ready,
  // captured video
  input  wire logic [1:0]  out_mode,
  output logic             vid_valid,
  output logic             vid_fval,
  output logic             vid_lval,
  output logic [9:0]       vid_a,
  output logic [9:0]       vid_b,
  // serial user side
  input  wire logic [7:0]  ser_tx_data,
  input  wire logic        ser_tx_valid,
  output logic             ser_tx_ready,
  output logic [7:0]       ser_rx_data,
  output logic             ser_rx_valid,
  output logic             ser_rx_err
);
  localparam int unsigned OW = $clog2(OVH_PIX + 1);

  ttc_trig_e   tg_q, tg_d;
  logic [31:0] per_q, per_d, wid_q, wid_d, hcnt_q, hcnt_d;
  logic        pulse_q, pulse_d, armed_q, armed_d, rdy_q, rdy_d;
  logic [32:0] reach;
  logic [27:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  logic        pc_old_q;
  logic [OW-1:0] ovh_q, ovh_d;
  logic        vv_q, vv_d, vf_q, vf_d, vl_q, vl_d;
  logic [9:0]  va_q, va_d, vb_q, vb_d;
  logic        rise, ovh_ok;

  // serial port
  // separate lines
  ttc_uart #(.BIT_CYC(BIT_CYC)) u_ser (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .tx_data  (ser_tx_data),
    .tx_valid (ser_tx_valid),
    .tx_ready (ser_tx_ready),
    .txd      (lnk.ser_to_cam),
    .rxd      (lnk.ser_to_fg),
    .rx_data  (ser_rx_data),
    .rx_valid (ser_rx_valid),
    .rx_err   (ser_rx_err)
  );

  // trigger: width clamp, period window, overhead after frame
  always_comb
  begin
    tg_d    = tg_q;
    per_d   = (per_q == 32'hffffffff) ? per_q : per_q + 32'h1;
    wid_d   = wid_q;
    hcnt_d  = hcnt_q;
    pulse_d = pulse_q;
    armed_d = armed_q;
    ovh_ok  = (ovh_q == OW'(OVH_PIX)) && !flt_q[2];
    reach   = {1'b0, per_q} + {1'b0, wid_q};
    rdy_d   = 1'b0;
    case (tg_q)
      TG_IDLE:
      begin
        rdy_d = ovh_ok && (!armed_q || reach >= 33'(PER_MIN));
        if (trig_req && rdy_q)
        begin
          wid_d = (trig_width < 32'(TRIG_MIN_CYC)) ? 32'(TRIG_MIN_CYC) : trig_width;
          tg_d = TG_HIGH;
          pulse_d = 1'b1;
          hcnt_d = 32'h0;
        end
        else if (armed_q && ovh_ok && reach >= 33'(PER_MAX))
        begin
          tg_d = TG_HIGH;
          pulse_d = 1'b1;
          hcnt_d = 32'h0;
        end
      end
      TG_HIGH:
      begin
        hcnt_d = hcnt_q + 32'h1;
        if (hcnt_q >= wid_q - 32'h1)
        begin
          tg_d = TG_IDLE;
          pulse_d = 1'b0;
          per_d = 32'h0;  // period runs between falling edges
          armed_d = 1'b1;
        end
      end
      default:
        tg_d = TG_IDLE;
    endcase
  end

  // video capture: three-stage pin sampling, sample on pixel rising edge
  always_comb
  begin
    flt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);
    rise  = flt_q[0] && !pc_old_q;
    ovh_d = ovh_q;
    vv_d  = vv_q;
    vf_d  = vf_q;
    vl_d  = vl_q;
    va_d  = va_q;
    vb_d  = vb_q;
    if (rise)
    begin
      vf_d = flt_q[1];
      vl_d = flt_q[2];
      vv_d = flt_q[3] & flt_q[2];
      if (out_mode == MODE_2TAP_10)
      begin
        va_d = {flt_q[13:12], flt_q[11:4]};
        vb_d = {flt_q[17:16], flt_q[27:20]};
      end
      else
      begin
        va_d = {flt_q[11:4], 2'b00};
        vb_d = {flt_q[19:12], 2'b00};
      end
      if (flt_q[1])
        ovh_d = '0;
      else if (ovh_q != OW'(OVH_PIX))
        ovh_d = ovh_q + OW'(1);
    end
    else
      vv_d = 1'b0;
  end

  // grabber registers
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      tg_q     <= TG_IDLE;
      per_q    <= 32'h0;
      wid_q    <= 32'(TRIG_MIN_CYC);
      hcnt_q   <= 32'h0;
      pulse_q  <= 1'b0;
      armed_q  <= 1'b0;
      rdy_q    <= 1'b0;
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      flt_q    <= '0;
      pc_old_q <= 1'b0;
      ovh_q    <= OW'(OVH_PIX);
      vv_q     <= 1'b0;
      vf_q     <= 1'b0;
      vl_q     <= 1'b0;
      va_q     <= 10'h000;
      vb_q     <= 10'h000;
    end
    else
    begin
      tg_q     <= tg_d;
      per_q    <= per_d;
      wid_q    <= wid_d;
      hcnt_q   <= hcnt_d;
      pulse_q  <= pulse_d;
      armed_q  <= armed_d;
      rdy_q    <= rdy_d;
      s1_q     <= {lnk.port_c, lnk.port_b, lnk.port_a, lnk.dval, lnk.lval,
                   lnk.fval, lnk.pix_clk};
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      flt_q    <= flt_d;
      pc_old_q <= flt_q[0];
      ovh_q    <= ovh_d;
      vv_q     <= vv_d;
      vf_q     <= vf_d;
      vl_q     <= vl_d;
      va_q     <= va_d;
      vb_q     <= vb_d;
    end
  end

  assign lnk.frame_trigger_pulse = pulse_q;
  assign lnk.cc_rsv  = 3'h0;
  assign trig_ready  = rdy_q;
  assign vid_valid   = vv_q;
  assign vid_fval    = vf_q;
  assign vid_lval    = vl_q;
  assign vid_a       = va_q;
  assign vid_b       = vb_q;
endmodule

// [sim/ttc_checker.sv]
// concurrent checks on the link between camera end and grabber end
`timescale 1ns/1ps
module ttc_checker
  import ttc_pkg::*;
#(
  parameter int unsigned PER_MIN = 4000
)(
  // clock and reset
  input logic       mclk,
  input logic       rst_b,
  // video
  input logic       fval,
  input logic       lval,
  input logic       dval,
  input logic [7:0] port_a,
  input logic [7:0] port_b,
  input logic [7:0] port_c,
  // control lines
  input logic       frame_trigger_pulse,
  input logic [2:0] cc_rsv
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // trigger width and period counters
  // ---------------------------------------------------------------
  logic [15:0] tw_q, tw_d, per_q, per_d, xf_q, xf_d;
  logic        tp_q, xa_q, xa_d;

  // high time of the pulse, time since its last fall (saturating)
  always_comb
  begin
    tw_d  = frame_trigger_pulse ? tw_q + 16'h1 : 16'h0;
    per_d = per_q + {15'h0, per_q != 16'hffff};
    xf_d  = xf_q + {15'h0, xf_q != 16'hffff};
    xa_d  = xa_q && !fval;  // waiting for fval after a trigger fall
    if (tp_q && !frame_trigger_pulse)
    begin
      per_d = 16'h1;
      xf_d  = 16'h1;
      xa_d  = 1'b1;
    end
  end

  // register the counters
  always_ff @(posedge mclk)
    if (!rst_b)
      {tw_q, per_q, tp_q, xf_q, xa_q} <= {16'h0, 16'hffff, 1'b0, 16'hffff, 1'b0};
    else
      {tw_q, per_q, tp_q, xf_q, xa_q} <= {tw_d, per_d, frame_trigger_pulse, xf_d, xa_d};

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  // line opens frame
  property p_fl; $rose(fval) |-> $rose(lval); endproperty
  property p_lf; $fell(fval) |-> $fell(lval); endproperty
  property p_lv; lval |-> fval; endproperty
  property p_dv; dval == lval; endproperty
  property p_idle; !dval |-> {port_a, port_b, port_c} == 24'h0; endproperty
  property p_cc; cc_rsv == 3'h0; endproperty
  property p_tw; $fell(frame_trigger_pulse) |-> tw_q >= TRIG_MIN_CYC; endproperty
  property p_per; $fell(frame_trigger_pulse) |-> per_q >= PER_MIN; endproperty
  property p_xf; $rose(fval) |-> xf_q >= TRANSFER_CYC; endproperty
  // transfer delay, latest rise (one pixel period plus filter slack)
  property p_xw; xa_q |-> xf_q <= TRANSFER_CYC + 2 * PCLK_HALF_CYC + 8; endproperty

  a_fl: assert property (p_fl) else $error("fval rose without lval");
  a_lf: assert property (p_lf) else $error("fval fell without lval");
  a_lv: assert property (p_lv) else $error("lval outside fval");
  a_dv: assert property (p_dv) else $error("dval differs from lval");
  a_idle: assert property (p_idle) else $error("data not zero when idle");
  a_cc: assert property (p_cc) else $error("reserved lines driven");
  a_tw: assert property (p_tw) else $error("trigger pulse too short");
  a_per: assert property (p_per) else $error("trigger period too short");
  a_xf: assert property (p_xf) else $error("fval early after trigger");
  a_xw: assert property (p_xw) else $error("fval late after trigger");

  // main scenarios
  c_trig: cover property ($fell(frame_trigger_pulse));
  c_gap: cover property ($fell(lval) && fval);
  c_end: cover property ($fell(fval));
endmodule

// [sim/two_tap_camera_video_output_test.sv]
// self-checking bench joining camera end and grabber end
`timescale 1ns/1ps
module two_tap_camera_video_output_test;
  import ttc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  mode = 2'h2;
  logic [9:0]  pa = 10'h0, pb = 10'h0, va, vb;
  logic        trq = 1'b0, trdy, take, busy, vv, vf, vl;
  logic [31:0] tw = 32'h0;
  logic [31:0] s = 32'h0000961e;
  logic [7:0]  td [2] = '{8'h0, 8'h0};
  logic        tv [2] = '{1'b0, 1'b0};
  logic        tr [2], rv [2], re [2];
  logic [7:0]  rd [2];
  logic [19:0] q [$];
  logic [7:0]  sq [2][$];
  int          checks = 0, n_mismatch = 0, cyc = 0, npair = 0;

  ttc_link_if lk();

  ttc_cam_end #(.BIT_CYC(16), .PAIRS(4), .LINES(3))
  i_ttc_cam_end (.mclk(mclk), .rst_b(rst_b), .lnk(lk), .out_mode(mode),
    .pix_a(pa), .pix_b(pb), .pix_take(take), .frame_busy(busy),
    .ser_tx_data(td[0]), .ser_tx_valid(tv[0]), .ser_tx_ready(tr[0]),
    .ser_rx_data(rd[1]), .ser_rx_valid(rv[1]), .ser_rx_err(re[1]));

  ttc_grab_end #(.BIT_CYC(16), .PER_MIN(4000))
  i_ttc_grab_end (.mclk(mclk), .rst_b(rst_b), .lnk(lk), .trig_req(trq),
    .trig_width(tw), .trig_ready(trdy), .out_mode(mode), .vid_valid(vv),
    .vid_fval(vf), .vid_lval(vl), .vid_a(va), .vid_b(vb),
    .ser_tx_data(td[1]), .ser_tx_valid(tv[1]), .ser_tx_ready(tr[1]),
    .ser_rx_data(rd[0]), .ser_rx_valid(rv[0]), .ser_rx_err(re[0]));

  ttc_checker i_ttc_checker (.mclk(mclk), .rst_b(rst_b),
    .fval(lk.fval), .lval(lk.lval), .dval(lk.dval), .port_a(lk.port_a),
    .port_b(lk.port_b), .port_c(lk.port_c), .cc_rsv(lk.cc_rsv),
    .frame_trigger_pulse(lk.frame_trigger_pulse));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // xorshift step
  task nx;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
  endtask

  // compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask

  // report and end the run
  task test_done;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one serial character from end g, watched bit by bit on its line
  task automatic send(input int g, input logic [7:0] d);
    logic [9:0] w;
    w = {1'b1, d, 1'b0};
    sq[g].push_back(d);
    while (tr[g] !== 1'b1) @(negedge mclk);
    td[g] = d;
    tv[g] = 1'b1;
    @(negedge mclk);
    tv[g] = 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      repeat (k ? 16 : 7) @(negedge mclk);
      chk("line", w[k], g ? lk.ser_to_cam : lk.ser_to_fg);
    end
  endtask

  // one triggered frame in mode m, then count the pairs seen
  task frame(input logic [1:0] m);
    mode = m;
    npair = 0;
    while (trdy !== 1'b1) @(negedge mclk);
    nx;
    // widths on both sides of the shortest pulse
    tw = 32'(TRIG_MIN_CYC - 32) + {26'h0, s[5:0]};
    trq = 1'b1;
    @(negedge mclk);
    trq = 1'b0;
    while (vf !== 1'b1) @(negedge mclk);
    while (vf === 1'b1) @(negedge mclk);
    chk("pairs", 12, npair);
    chk("busy", 0, busy);
  endtask

  // ---------------------------------------------------------------
  // drivers and watchers
  // ---------------------------------------------------------------
  // clock
  initial
  begin
    forever #2 mclk = ~mclk;
  end

  // pixel source: note the taken pair, check the wire, offer the next
  always @(negedge mclk)
    if (take === 1'b1)
    begin
      q.push_back(mode == 2'h3 ? {pa, pb} : {pa[9:2], 2'h0, pb[9:2], 2'h0});
      chk("ports", mode == 2'h3 ? {pa[7:0], 2'h0, pb[9:8], 2'h0, pa[9:8], pb[7:0]}
        : {pa[9:2], pb[9:2], 8'h0}, {lk.port_a, lk.port_b, lk.port_c});
      nx;
      pa = s[9:0];
      pb = s[19:10];
    end

  // result watcher and run limit
  always @(negedge mclk)
  begin
    if (vv === 1'b1)
    begin
      npair++;
      chk("video", q.pop_front(), {va, vb});
      chk("lval busy", 2'h3, {vl, busy});
    end
    for (int g = 0; g < 2; g++)
    begin
      if (rv[g] === 1'b1)
        chk("serial", sq[g].pop_front(), rd[g]);
      if (re[g] !== 1'b0 && rst_b)
        chk("frame err", 0, 1);
    end
    cyc++;
    if (cyc == 99000)
    begin
      n_mismatch++;
      test_done;
    end
  end

  // main sequence
  initial
  begin
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    fork
      repeat (4)
      begin
        nx;
        send(0, s[7:0]);
      end
      repeat (4)
      begin
        nx;
        send(1, s[15:8]);
      end
    join
    for (int m = 0; m < 4; m++)
      frame(m[1:0]);
    test_done;
  end
endmodule
